// *** src/pcrms_pkg.sv ***
// Constants, register map and arithmetic helpers for the phase trim and current rms block
package pcrms_pkg;

  // ----------------------------------------------------------------
  // Data widths
  // ----------------------------------------------------------------
  localparam int unsigned I_W     = 24;
  localparam int unsigned RMS_W   = 24;
  localparam int unsigned SQ_W    = 48;
  localparam int unsigned TRIM_W  = 5;
  localparam int unsigned GAIN_W  = 12;
  localparam int unsigned OFS_W   = 12;
  localparam int unsigned XT_W    = 16;
  localparam int unsigned ADDR_W  = 10;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned NPHASE  = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned REF_CLK_MHZ   = 10;
  localparam int unsigned TRIM_STEP_NS  = 1200;
  localparam int unsigned TRIM_STEP_CYC = (TRIM_STEP_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int unsigned RMS_RATE_DIV  = 12;
  localparam int unsigned DLY_DEPTH     = 32;
  localparam logic [TRIM_W-1:0] DLY_NOM = 5'h10;

  // ----------------------------------------------------------------
  // Arithmetic scaling
  // ----------------------------------------------------------------
  localparam logic [GAIN_W:0] GAIN_UNITY  = 13'h1000;
  localparam int unsigned     GAIN_SHIFT  = 12;
  localparam int unsigned     OFS_SHIFT   = 15;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_TRIM_A  = 8'h20;
  localparam logic [7:0] IDX_GAIN_A  = 8'h23;
  localparam logic [7:0] IDX_OFS_A   = 8'h26;
  localparam logic [7:0] IDX_RMS_A   = 8'h29;
  localparam logic [7:0] IDX_XTALK   = 8'h3D;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [TRIM_W-1:0] RST_TRIM  = 5'h00;
  localparam logic [GAIN_W-1:0] RST_GAIN  = 12'h000;
  localparam logic [OFS_W-1:0]  RST_OFS   = 12'h000;
  localparam logic [XT_W-1:0]   RST_XTALK = 16'h0000;

  // Square times (1 + gain/4096)
  function automatic logic [SQ_W-1:0] gain_scale(input logic [SQ_W-1:0]   sq,
                                                 input logic [GAIN_W-1:0] g);
    logic [GAIN_W:0]          mult;
    logic [SQ_W+GAIN_W:0]     prod;
    mult = GAIN_UNITY + {g[GAIN_W-1], g};
    prod = sq * mult;
    return prod[SQ_W+GAIN_SHIFT-1:GAIN_SHIFT];
  endfunction

  // Restoring integer square root
  function automatic logic [RMS_W-1:0] isqrt(input logic [SQ_W-1:0] x);
    logic [SQ_W+1:0]  rem;
    logic [SQ_W+1:0]  trial;
    logic [RMS_W-1:0] root;
    rem  = '0;
    root = '0;
    for (int i = RMS_W - 1; i >= 0; i--) begin
      rem   = {rem[SQ_W-1:0], x[2*i+1], x[2*i]};
      trial = {{(SQ_W-RMS_W){1'b0}}, root, 2'b01};
      if (rem >= trial) begin
        rem  = rem - trial;
        root = {root[RMS_W-2:0], 1'b1};
      end else begin
        root = {root[RMS_W-2:0], 1'b0};
      end
    end
    return root;
  endfunction

endpackage

// *** src/pcrms_top.sv ***
// Voltage path delay trim and per-phase current rms with APB register access
//
// Functional notes
// R1 - Trim zero: voltage and current paths carry identical delay at all frequencies.
// R2 - Each phase has a 5-bit signed trim shifting only its voltage path.
// R3 - One trim count shifts the voltage path by one sample step of 1.2 us.
// R4 - Negative trim shortens voltage delay, advancing voltage against current.
// R5 - Software keeps trims small; time shift distorts phase of harmonics.
// R6 - Rms is square, low-pass filter, then square root.
// R7 - All channels processed concurrently, each result in its own register.
// R8 - Rms input is the waveform current sample after power gain scaling.
// R9 - Current rms is unsigned 24-bit, one count equals one sample count.
// R10 - Current rms results refresh at master clock divided by twelve.
// R11 - Full-scale sine input gives about 1,898,124 counts.
// R12 - Rms scaled by square root of one plus gain over 4096.
// R13 - Power gain is two's complement, 7FFh largest, 800h most negative.
// R14 - Each phase has a 12-bit signed rms offset value.
// R15 - Offset times 32768 added to squared rms before square root.
// R16 - Software writes only 01F7h to the crosstalk location 3Dh.
// R17 - Software derives offset from readings near full scale and full scale/100.
// R18 - Negative corrected square clamps to zero before square root.
// R19 - New trim, gain or offset applies from next processed sample.
`timescale 1ns/10ps
module pcrms_top #(
  parameter int unsigned V_W       = 16,
  parameter int unsigned LPF_SHIFT = 10
) (
  // Clock and reset
  input  wire logic                           CLK,
  input  wire logic                           RST,
  // APB slave
  input  wire logic                           PSEL,
  input  wire logic                           PENABLE,
  input  wire logic                           PWRITE,
  input  wire logic [pcrms_pkg::ADDR_W-1:0]   PADDR,
  input  wire logic [pcrms_pkg::DATA_W-1:0]   PWDATA,
  output logic      [pcrms_pkg::DATA_W-1:0]   PRDATA,
  output logic                                PREADY,
  output logic                                PSLVERR,
  // Current samples in
  input  wire logic [pcrms_pkg::I_W-1:0]      CURRENT_IN_A,
  input  wire logic [pcrms_pkg::I_W-1:0]      CURRENT_IN_B,
  input  wire logic [pcrms_pkg::I_W-1:0]      CURRENT_IN_C,
  // Voltage samples in
  input  wire logic [V_W-1:0]                 VOLTAGE_IN_A,
  input  wire logic [V_W-1:0]                 VOLTAGE_IN_B,
  input  wire logic [V_W-1:0]                 VOLTAGE_IN_C,
  // Aligned samples out
  output logic                                SAMPLE_TICK,
  output logic      [pcrms_pkg::I_W-1:0]      CURRENT_OUT_A,
  output logic      [pcrms_pkg::I_W-1:0]      CURRENT_OUT_B,
  output logic      [pcrms_pkg::I_W-1:0]      CURRENT_OUT_C,
  output logic      [V_W-1:0]                 VOLTAGE_OUT_A,
  output logic      [V_W-1:0]                 VOLTAGE_OUT_B,
  output logic      [V_W-1:0]                 VOLTAGE_OUT_C
);
  import pcrms_pkg::*;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  generate
    if (V_W < 8 || V_W > 24) begin : g_bad_vw
      $error("V_W must lie in 8..24");
    end
    if (LPF_SHIFT < 1 || LPF_SHIFT > 16) begin : g_bad_lpf
      $error("LPF_SHIFT must lie in 1..16");
    end
    if (TRIM_STEP_CYC != RMS_RATE_DIV) begin : g_bad_rate
      $error("Trim step and rms refresh must share one sample rate");
    end
  endgenerate

  localparam int unsigned ACC_W = SQ_W + LPF_SHIFT;
  localparam logic [3:0]  DIV_LAST = 4'(RMS_RATE_DIV - 1);

  // ----------------------------------------------------------------
  // Sample rate divider
  // ----------------------------------------------------------------
  logic [3:0] div_cnt;
  wire        tick = (div_cnt == DIV_LAST);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= tick ? 4'h0 : div_cnt + 4'h1; // R10 R3
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SAMPLE_TICK <= 1'b0;
    end else begin
      SAMPLE_TICK <= tick;
    end
  end

  // ----------------------------------------------------------------
  // Configuration and result registers
  // ----------------------------------------------------------------
  logic [TRIM_W-1:0] trim  [NPHASE];
  logic [GAIN_W-1:0] gain  [NPHASE];
  logic [OFS_W-1:0]  ofs   [NPHASE];
  logic [RMS_W-1:0]  rms   [NPHASE];
  logic [XT_W-1:0]   xtalk;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic              bad_req;
  logic [1:0]        sel_ph;
  logic [2:0]        sel_kind;
  logic              hit;
  logic              writable;
  logic [DATA_W-1:0] rd_val;

  wire [7:0] idx     = PADDR[ADDR_W-1:2];
  wire       aligned = (PADDR[1:0] == 2'b00);
  wire       access  = PSEL && PENABLE && PREADY;
  wire       wr_go   = access && PWRITE && !bad_req;

  // Phase offset within a three-word group
  function automatic logic [1:0] ph_of(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return d[1:0];
  endfunction

  always_comb begin
    sel_ph   = 2'd0;
    sel_kind = 3'd0;
    hit      = 1'b0;
    writable = 1'b0;
    if (!aligned) begin
      hit = 1'b0;
    end else if (idx >= IDX_TRIM_A && idx < IDX_TRIM_A + 8'h03) begin
      sel_kind = 3'd1;
      sel_ph   = ph_of(idx, IDX_TRIM_A);
      hit      = 1'b1;
      writable = 1'b1;
    end else if (idx >= IDX_GAIN_A && idx < IDX_GAIN_A + 8'h03) begin
      sel_kind = 3'd2;
      sel_ph   = ph_of(idx, IDX_GAIN_A);
      hit      = 1'b1;
      writable = 1'b1;
    end else if (idx >= IDX_OFS_A && idx < IDX_OFS_A + 8'h03) begin
      sel_kind = 3'd3;
      sel_ph   = ph_of(idx, IDX_OFS_A);
      hit      = 1'b1;
      writable = 1'b1;
    end else if (idx >= IDX_RMS_A && idx < IDX_RMS_A + 8'h03) begin
      sel_kind = 3'd4;
      sel_ph   = ph_of(idx, IDX_RMS_A);
      hit      = 1'b1;
    end else if (idx == IDX_XTALK) begin
      sel_kind = 3'd5;
      hit      = 1'b1;
      writable = 1'b1;
    end
  end

  always_comb begin
    case (sel_kind)
      3'd1:    rd_val = {{(DATA_W-TRIM_W){1'b0}}, trim[sel_ph]};
      3'd2:    rd_val = {{(DATA_W-GAIN_W){1'b0}}, gain[sel_ph]};
      3'd3:    rd_val = {{(DATA_W-OFS_W){1'b0}}, ofs[sel_ph]};
      3'd4:    rd_val = {{(DATA_W-RMS_W){1'b0}}, rms[sel_ph]};
      3'd5:    rd_val = {{(DATA_W-XT_W){1'b0}}, xtalk};
      default: rd_val = '0;
    endcase
  end

  // Error for unmapped addresses and writes to read-only words
  always_comb begin
    bad_req = !hit || (PWRITE && !writable);
  end

  // One wait state: answer registered in the first access cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
      if (PSEL && PENABLE && !PREADY) begin
        PRDATA  <= (PWRITE || bad_req) ? '0 : rd_val;
        PSLVERR <= bad_req;
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // Register writes take effect at the completing edge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int p = 0; p < NPHASE; p++) begin
        trim[p] <= RST_TRIM;
        gain[p] <= RST_GAIN;
        ofs[p]  <= RST_OFS;
      end
      xtalk <= RST_XTALK;
    end else if (wr_go) begin
      case (sel_kind)
        3'd1:    trim[sel_ph] <= PWDATA[TRIM_W-1:0]; // R2 R19
        3'd2:    gain[sel_ph] <= PWDATA[GAIN_W-1:0]; // R13 R19
        3'd3:    ofs[sel_ph]  <= PWDATA[OFS_W-1:0];  // R14 R19
        3'd5:    xtalk        <= PWDATA[XT_W-1:0];   // R16
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Delay lines, one sample per tick
  // ----------------------------------------------------------------
  logic [I_W-1:0] cur_in  [NPHASE];
  logic [V_W-1:0] vol_in  [NPHASE];
  logic [I_W-1:0] cur_dly [NPHASE];
  logic [V_W-1:0] vol_dly [NPHASE];
  logic [4:0]     wp;

  assign cur_in[0] = CURRENT_IN_A;
  assign cur_in[1] = CURRENT_IN_B;
  assign cur_in[2] = CURRENT_IN_C;
  assign vol_in[0] = VOLTAGE_IN_A;
  assign vol_in[1] = VOLTAGE_IN_B;
  assign vol_in[2] = VOLTAGE_IN_C;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wp <= 5'h00;
    end else if (tick) begin
      wp <= wp + 5'h01;
    end
  end

  generate
    for (genvar p = 0; p < NPHASE; p++) begin : g_phase
      logic [I_W-1:0]   cmem [DLY_DEPTH];
      logic [V_W-1:0]   vmem [DLY_DEPTH];
      logic [SQ_W-1:0]  sq;
      logic [ACC_W-1:0] acc;

      // Voltage delay is nominal plus signed trim, 0..31 samples
      wire [4:0] v_delay = DLY_NOM + trim[p];             // R2 R3 R4
      wire [4:0] v_rd    = wp - v_delay;
      wire [4:0] c_rd    = wp - DLY_NOM;                  // R1
      wire [V_W-1:0] v_pick = (v_delay == 5'h00) ? vol_in[p] : vmem[v_rd];

      wire signed [I_W-1:0]  c_s   = signed'(cur_dly[p]);
      wire signed [SQ_W-1:0] c_sq  = SQ_W'(c_s) * SQ_W'(c_s);
      wire [SQ_W-1:0]        filt  = acc[ACC_W-1:LPF_SHIFT];
      wire signed [SQ_W:0]   ofs_w = (SQ_W+1)'(signed'(ofs[p])) <<< OFS_SHIFT;
      wire signed [SQ_W:0]   corr  = signed'({1'b0, filt}) + ofs_w;   // R15
      wire [SQ_W-1:0]        clamp = corr[SQ_W] ? '0 : corr[SQ_W-1:0]; // R18

      // Cleared so the filter never starts from stale contents
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          for (int k = 0; k < DLY_DEPTH; k++) begin
            cmem[k] <= '0;
            vmem[k] <= '0;
          end
        end else if (tick) begin
          cmem[wp] <= cur_in[p];
          vmem[wp] <= vol_in[p];
        end
      end

      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          cur_dly[p] <= '0;
          vol_dly[p] <= '0;
        end else if (tick) begin
          cur_dly[p] <= cmem[c_rd]; // R1
          vol_dly[p] <= v_pick;     // R4
        end
      end

      // Square with gain, low-pass, offset, root at the sample rate
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          sq     <= '0;
          acc    <= '0;
          rms[p] <= '0;
        end else if (tick) begin
          sq     <= gain_scale(c_sq, gain[p]);                        // R8 R12 R13
          acc    <= acc + ACC_W'(sq) - ACC_W'(acc[ACC_W-1:LPF_SHIFT]); // R6
          rms[p] <= isqrt(clamp);                                     // R6 R7 R9 R10 R11
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output mapping
  // ----------------------------------------------------------------
  assign CURRENT_OUT_A = cur_dly[0];
  assign CURRENT_OUT_B = cur_dly[1];
  assign CURRENT_OUT_C = cur_dly[2];
  assign VOLTAGE_OUT_A = vol_dly[0];
  assign VOLTAGE_OUT_B = vol_dly[1];
  assign VOLTAGE_OUT_C = vol_dly[2];

endmodule

// *** verification/pcrms_top_sva.sv ***
// Port checker for the phase trim and current rms block
`timescale 1ns/10ps
module pcrms_top_sva #(
  parameter int unsigned V_W = 16
) (
  // Clock and reset
  input wire logic                          CLK,
  input wire logic                          RST,
  // Register bus
  input wire logic                          PSEL,
  input wire logic                          PENABLE,
  input wire logic                          PWRITE,
  input wire logic [pcrms_pkg::ADDR_W-1:0]  PADDR,
  input wire logic [pcrms_pkg::DATA_W-1:0]  PRDATA,
  input wire logic                          PREADY,
  input wire logic                          PSLVERR,
  // Aligned samples
  input wire logic                          SAMPLE_TICK,
  input wire logic [pcrms_pkg::I_W-1:0]     CURRENT_OUT_A,
  input wire logic [pcrms_pkg::I_W-1:0]     CURRENT_OUT_B,
  input wire logic [pcrms_pkg::I_W-1:0]     CURRENT_OUT_C,
  input wire logic [V_W-1:0]                VOLTAGE_OUT_A,
  input wire logic [V_W-1:0]                VOLTAGE_OUT_B,
  input wire logic [V_W-1:0]                VOLTAGE_OUT_C
);
  import pcrms_pkg::*;
  // ------
  // Decode
  // ------
  wire acc     = PSEL && PENABLE && !PREADY;
  wire rms_hit = PADDR[9:2] >= IDX_RMS_A && PADDR[9:2] <= IDX_RMS_A + 8'h02;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // ------
  // Assertions
  // ------
  a_ready_answer: assert property (acc |=> PREADY)
    else $error("no ready one cycle after access");
  a_ready_cause: assert property (PREADY |-> $past(acc))
    else $error("ready without access");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_qual: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_err_unaligned: assert property (acc && PADDR[1:0] != 2'b00 |=> PSLVERR)
    else $error("unaligned access accepted");
  a_err_rms_write: assert property (acc && PWRITE && rms_hit |=> PSLVERR)
    else $error("write to rms word accepted");
  a_err_no_data: assert property (PREADY && PSLVERR |-> PRDATA == '0)
    else $error("refused access returned data");
  a_upper_zero: assert property (PREADY && !PWRITE |-> PRDATA[31:24] == 8'h00)
    else $error("upper read bits not zero");
  a_tick_period: assert property (SAMPLE_TICK |-> ##12 SAMPLE_TICK)
    else $error("tick period not twelve");
  a_tick_gap: assert property (SAMPLE_TICK |=> !SAMPLE_TICK [*8])
    else $error("tick inside period");
  a_out_hold: assert property (!SAMPLE_TICK |-> $stable({CURRENT_OUT_A, CURRENT_OUT_B,
    CURRENT_OUT_C, VOLTAGE_OUT_A, VOLTAGE_OUT_B, VOLTAGE_OUT_C}))
    else $error("samples changed off tick");
  c_write_ok: cover property (PREADY && !PSLVERR && PWRITE);
  c_refused: cover property (PREADY && PSLVERR);
  c_read_data: cover property (PREADY && !PWRITE && PRDATA != '0);
endmodule

bind pcrms_top pcrms_top_sva #(.V_W(V_W)) u_pcrms_sva (
  .CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR,
  .SAMPLE_TICK, .CURRENT_OUT_A, .CURRENT_OUT_B, .CURRENT_OUT_C,
  .VOLTAGE_OUT_A, .VOLTAGE_OUT_B, .VOLTAGE_OUT_C
);

// *** verification/test_phase_comp_current_rms.sv ***
// Self-checking bench for the phase trim and current rms block
`timescale 1ns/10ps
module test_phase_comp_current_rms;
  import pcrms_pkg::*;
  // ------
  // Signals
  // ------
  logic              clk = 0;
  logic              rst = 1;
  logic              psel = 0;
  logic              penable = 0;
  logic              pwrite = 0;
  logic [9:0]        paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              tick;
  logic [I_W-1:0]    ci [3] = '{default: '0};
  logic [15:0]       vi [3] = '{default: '0};
  logic [I_W-1:0]    co [3];
  logic [15:0]       vo [3];
  logic [31:0]       rd;
  logic              ramp_on = 0;
  logic [15:0]       ramp = '0;
  int                errors = 0;
  int                check_count = 0;
  int                tr [3];
  int                iv [3];
  int                gv [3];
  int                ov [3];
  localparam int IT [2][3] = '{'{1898124, 1000, -2684354}, '{-1898124, 1000, 18981}};
  localparam int GT [2][3] = '{'{0, 2047, -2048}, '{0, 0, 100}};
  localparam int OT [2][3] = '{'{0, 0, 0}, '{2047, -2048, 16}};

  pcrms_top #(.V_W(16), .LPF_SHIFT(4)) dut (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CURRENT_IN_A(ci[0]), .CURRENT_IN_B(ci[1]),
    .CURRENT_IN_C(ci[2]), .VOLTAGE_IN_A(vi[0]), .VOLTAGE_IN_B(vi[1]),
    .VOLTAGE_IN_C(vi[2]), .SAMPLE_TICK(tick), .CURRENT_OUT_A(co[0]),
    .CURRENT_OUT_B(co[1]), .CURRENT_OUT_C(co[2]), .VOLTAGE_OUT_A(vo[0]),
    .VOLTAGE_OUT_B(vo[1]), .VOLTAGE_OUT_C(vo[2])
  );

  initial begin
    forever #20 clk = ~clk;
  end

  // Same ramp on every path, one step a sample
  always @(posedge clk) begin
    if (ramp_on && tick === 1'b1) begin
      ramp <= ramp + 16'h0001;
      for (int p = 0; p < 3; p++) begin
        ci[p] <= 24'(ramp);
        vi[p] <= ramp;
      end
    end
  end

  // ------
  // Tasks
  // ------
  task automatic results();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic fail(input string msg);
    errors++;
    $display("BAD %0t %s", $time, msg);
  endtask

  task automatic chk(input logic [31:0] got, input longint exp, input int tol);
    longint d;
    d = longint'(got) - exp;
    check_count++;
    if ($isunknown(got) || d > tol || d < -tol) begin
      errors++;
      $display("BAD %0t got %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
                     input logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail("bus timeout");
      results();
    end
    rd = prdata;
    chk(32'(pslverr), longint'(e), 0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ticks(input int n);
    int c;
    repeat (n) begin
      c = 0;
      do begin
        @(posedge clk);
        c++;
      end while (tick !== 1'b1 && c < 30);
      if (c >= 30) begin
        fail("tick timeout");
        results();
      end
    end
  endtask

  function automatic longint expect_rms(input longint i, input longint g, input longint o);
    longint s;
    s = i * i * (4096 + g) / 4096 + o * 32768;
    if (s < 0) begin
      s = 0;
    end
    return longint'($floor($sqrt(real'(s))));
  endfunction

  // ------
  // Sequence
  // ------
  initial begin
    int a;
    logic [31:0] d;
    logic [31:0] m;
    void'($urandom(32'h71F2B526));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 8'h20; i <= 8'h2B; i++) begin
      apb(1'b0, 10'(i * 4), 32'h0, 1'b0);
      chk(rd, 0, 0);
    end
    for (int i = 0; i < 10; i++) begin
      a = (i == 9) ? 8'h3D : 8'h20 + i;
      m = (i < 3) ? 32'h1F : (i == 9) ? 32'hFFFF : 32'hFFF;
      d = (i == 9) ? 32'h01F7 : $urandom;
      apb(1'b1, 10'(a * 4), d, 1'b0);
      apb(1'b0, 10'(a * 4), 32'h0, 1'b0);
      chk(rd, longint'(d & m), 0);
      apb(1'b1, 10'(a * 4), (i == 9) ? 32'h01F7 : 32'h0, 1'b0);
    end
    apb(1'b1, 10'(IDX_RMS_A * 4), 32'h1, 1'b1);
    apb(1'b0, 10'h0B0, 32'h0, 1'b1);
    chk(rd, 0, 0);
    apb(1'b0, 10'h081, 32'h0, 1'b1);
    apb(1'b1, 10'(IDX_XTALK * 4), 32'h01F7, 1'b0);
    apb(1'b1, 10'h080, 32'h5, 1'b0);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b1, 10'(IDX_XTALK * 4), 32'h01F7, 1'b0);
    apb(1'b0, 10'h080, 32'h0, 1'b0);
    chk(rd, 0, 0);
    ramp_on <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      for (int p = 0; p < 3; p++) begin
        tr[p] = (c == 2) ? int'($urandom_range(31)) - 16 :
                (c == 0) ? 0 : (p == 0) ? -16 : (p == 1) ? -4 : 15;
        apb(1'b1, 10'((32 + p) * 4), 32'(tr[p] & 31), 1'b0);
      end
      ticks(40);
      for (int p = 0; p < 3; p++) begin
        chk(32'(16'(co[p][15:0] - vo[p])), longint'(tr[p] & 32'hFFFF), 0);
      end
    end
    ramp_on <= 1'b0;
    @(posedge clk);
    for (int c = 0; c < 3; c++) begin
      for (int p = 0; p < 3; p++) begin
        iv[p] = (c < 2) ? IT[c][p] : int'($urandom_range(2684354)) * ($urandom_range(1) ? 1 : -1);
        gv[p] = (c < 2) ? GT[c][p] : int'($urandom_range(4095)) - 2048;
        ov[p] = (c < 2) ? OT[c][p] : int'($urandom_range(4095)) - 2048;
        ci[p] <= 24'(iv[p]);
        apb(1'b1, 10'((35 + p) * 4), 32'(gv[p] & 12'hFFF), 1'b0);
        apb(1'b1, 10'((38 + p) * 4), 32'(ov[p] & 12'hFFF), 1'b0);
      end
      ticks(500);
      for (int p = 0; p < 3; p++) begin
        apb(1'b0, 10'((41 + p) * 4), 32'h0, 1'b0);
        chk(rd, expect_rms(iv[p], gv[p], ov[p]), 2);
      end
    end
    results();
  end

  initial begin
    repeat (100000) @(posedge clk);
    fail("run timeout");
    results();
  end
endmodule
